// ==== core/lang_mv_seq.sv ====
// Sequencer for the block-move, parameter-entry and table-fill instructions
`include "lang_mv_map.svh"
// Notes on behaviour
// - Bit 15 set means indirect; follow chains
// - Eight-word move; A,B advance by eight
// - Opcode, destination, source; continue after third
// - Four-word move; A,B advance by four
// - Three-word inline move; A,B advance by three
// - Base-relative mode may adjust move addresses
// - Entry copies true parameter addresses, fixes return
// - Resolve every indirect level to direct
// - Privileged entry returns true return in A
// - Register move: source A, destination B, plus three
// - Fill: value A, address B, count inline
// - Fill writes count entries, value and address increment
// - Fill interruptible; B ends at start plus count
// - Base-relative mode may adjust fill addresses
module lang_mv_seq (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_start, // Pulse: opcode in i_opcode, located at i_p
	input wire logic [15:0] i_opcode,
	input wire logic [15:0] i_p, // Address of opcode word
	input wire lang_mv_pkg::acc_t i_acc, // Accumulators at start
	input wire logic i_irq, // Interrupt pending level
	input wire logic i_cds, // Base-relative segmentation active
	input wire logic [15:0] i_base, // Current base for base-relative mode
	input wire logic i_mem_ack, // Memory access done this cycle
	input wire logic [15:0] i_mem_rdata, // Read data valid with ack
	output lang_mv_pkg::mem_req_t o_mem, // Memory request, held until ack
	output lang_mv_pkg::acc_t o_acc, // Accumulators result
	output logic [15:0] o_p_next, // Next instruction address
	output logic o_busy, // Sequence running
	output logic o_done, // Pulse: finished, results valid
	output logic o_intr // Pulse: fill stopped for interrupt
);
	import lang_mv_pkg::*;

	// Sequencer states
	typedef enum logic [3:0] {S_IDLE, S_FETCH, S_IND, S_MRD, S_MWR, S_ERET, S_EPRM,
		S_ESTR, S_EFIX, S_FCNT, S_FWR, S_FSAV} state_t;

	state_t state_reg;
	kind_t kind_reg;
	logic [15:0] p_reg; // Instruction word pointer
	logic [15:0] a_reg, b_reg; // Working accumulators
	logic [15:0] cnt_reg; // Remaining words
	logic [15:0] dat_reg; // Word in transit
	logic [15:0] ret_reg; // Subroutine return slot address
	logic [15:0] dst_reg; // Parameter store pointer
	logic [1:0] widx_reg; // Inline word index
	state_t after_reg; // State taking resolved address
	mem_req_t mem_reg;
	logic done_reg, intr_reg;

	// Full-pattern opcode decode
	function automatic kind_t decode(input logic [15:0] op);
		unique case (op)
			`OP_MOVE8: decode = K_MOVE8;
			`OP_MOVE4: decode = K_MOVE4;
			`OP_MOVE3: decode = K_MOVE3;
			`OP_XFER3: decode = K_XFER3;
			`OP_ENTER_PRIV: decode = K_ENTER_PRIVILEGED_PARAMS;
			`OP_ENTER: decode = K_ENTER_PARAMS;
			`OP_FILL: decode = K_FILL;
			default: decode = K_NONE;
		endcase
	endfunction : decode

	// Base-relative adjust for data addresses
	function automatic logic [15:0] seg(input logic [15:0] ad, input logic c, input logic [15:0] bs);
		seg = c ? ad + bs : ad;
	endfunction : seg

	wire kind_t dec_kind = decode(i_opcode);
	wire logic accept = i_start && (state_reg == S_IDLE) && (dec_kind != K_NONE);
	wire logic ack = mem_reg.req && i_mem_ack;
	wire logic is_ind = i_mem_rdata[`IND_BIT];
	wire logic [15:0] move_len = (kind_reg == K_MOVE8) ? `LEN_MOVE8 :
		(kind_reg == K_MOVE4) ? `LEN_MOVE4 : `LEN_MOVE3;
	wire logic is_entry = (kind_reg == K_ENTER_PRIVILEGED_PARAMS) || (kind_reg == K_ENTER_PARAMS);

	assign o_mem = mem_reg;
	assign o_acc = '{a: a_reg, b: b_reg};
	assign o_p_next = p_reg;
	assign o_busy = state_reg != S_IDLE;
	assign o_done = done_reg;
	assign o_intr = intr_reg;

	// Main sequencer
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= S_IDLE;
			kind_reg <= K_NONE;
			after_reg <= S_IDLE;
			{p_reg, a_reg, b_reg, cnt_reg, dat_reg, ret_reg, dst_reg} <= '0;
			widx_reg <= 2'h0;
			mem_reg <= '0;
			done_reg <= 1'b0;
			intr_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			intr_reg <= 1'b0;
			unique case (state_reg)
				S_IDLE: begin
					if (accept) begin
						kind_reg <= dec_kind;
						a_reg <= i_acc.a;
						b_reg <= i_acc.b;
						p_reg <= i_p + 16'h0001;
						widx_reg <= 2'h0;
						unique case (dec_kind)
							K_XFER3: begin
								cnt_reg <= `LEN_MOVE3;
								mem_reg <= '{req: 1'b1, wr: 1'b0,
									addr: seg(i_acc.a, i_cds, i_base), wdata: 16'h0000};
								state_reg <= S_MRD;
							end
							K_ENTER_PRIVILEGED_PARAMS, K_ENTER_PARAMS: begin
								// Return slot: two words before privileged entry, else one
								ret_reg <= (dec_kind == K_ENTER_PRIVILEGED_PARAMS) ? i_p - `ENTER_GAP
									: i_p - 16'h0001;
								dst_reg <= i_p + 16'h0001;
								// One parameter slot; kept here so i_p need not stand
								cnt_reg <= 16'h0001;
								mem_reg <= '{req: 1'b1, wr: 1'b0,
									addr: (dec_kind == K_ENTER_PRIVILEGED_PARAMS) ? i_p - `ENTER_GAP
									: i_p - 16'h0001, wdata: 16'h0000};
								state_reg <= S_ERET;
							end
							default: begin
								// Fetch inline word after the opcode
								mem_reg <= '{req: 1'b1, wr: 1'b0, addr: i_p + 16'h0001,
									wdata: 16'h0000};
								state_reg <= (dec_kind == K_FILL) ? S_FCNT : S_FETCH;
							end
						endcase
					end
				end
				S_FETCH: if (ack) begin
					// Inline addresses: destination then source
					p_reg <= p_reg + 16'h0001;
					if (is_ind) begin
						mem_reg.addr <= {1'b0, i_mem_rdata[14:0]};
						after_reg <= S_FETCH;
						state_reg <= S_IND;
					end else if (widx_reg == 2'h0) begin
						b_reg <= i_mem_rdata;
						widx_reg <= 2'h1;
						mem_reg.addr <= p_reg + 16'h0001;
					end else begin
						a_reg <= i_mem_rdata;
						cnt_reg <= move_len;
						mem_reg.addr <= seg(i_mem_rdata, i_cds, i_base);
						state_reg <= S_MRD;
					end
				end
				S_IND: if (ack) begin
					if (is_ind) begin
						mem_reg.addr <= {1'b0, i_mem_rdata[14:0]};
					end else if (after_reg == S_FETCH) begin
						if (widx_reg == 2'h0) begin
							b_reg <= i_mem_rdata;
							widx_reg <= 2'h1;
							mem_reg.addr <= p_reg;
						end else begin
							a_reg <= i_mem_rdata;
							cnt_reg <= move_len;
							mem_reg.addr <= seg(i_mem_rdata, i_cds, i_base);
							state_reg <= S_MRD;
						end
						if (widx_reg == 2'h0) state_reg <= S_FETCH;
					end else begin
						dat_reg <= i_mem_rdata;
						mem_reg <= '{req: 1'b1, wr: 1'b1, addr: dst_reg, wdata: i_mem_rdata};
						state_reg <= S_ESTR;
					end
				end
				S_MRD: if (ack) begin
					// Read one source word
					mem_reg <= '{req: 1'b1, wr: 1'b1, addr: seg(b_reg, i_cds, i_base),
						wdata: i_mem_rdata};
					state_reg <= S_MWR;
				end
				S_MWR: if (ack) begin
					// Write done; advance both addresses
					a_reg <= a_reg + 16'h0001;
					b_reg <= b_reg + 16'h0001;
					cnt_reg <= cnt_reg - 16'h0001;
					if (cnt_reg == 16'h0001) begin
						mem_reg <= '0;
						done_reg <= 1'b1;
						state_reg <= S_IDLE;
					end else begin
						mem_reg <= '{req: 1'b1, wr: 1'b0,
							addr: seg(a_reg + 16'h0001, i_cds, i_base), wdata: 16'h0000};
						state_reg <= S_MRD;
					end
				end
				S_ERET: if (ack) begin
					// Saved return points at first parameter word
					p_reg <= i_mem_rdata;
					mem_reg.addr <= i_mem_rdata;
					state_reg <= S_EPRM;
				end
				S_EPRM: if (ack) begin
					// Parameter word: follow if indirect, else store it as the true address
					if (i_mem_rdata[`IND_BIT] || (p_reg != mem_reg.addr)) begin
						mem_reg.addr <= {1'b0, i_mem_rdata[14:0]};
						after_reg <= S_ESTR;
						state_reg <= S_IND;
					end else begin
						dat_reg <= i_mem_rdata;
						mem_reg <= '{req: 1'b1, wr: 1'b1, addr: dst_reg, wdata: i_mem_rdata};
						state_reg <= S_ESTR;
					end
					p_reg <= p_reg + 16'h0001;
				end
				S_ESTR: if (ack) begin
					// Stored one true address; stop at instruction after list
					dst_reg <= dst_reg + 16'h0001;
					cnt_reg <= cnt_reg - 16'h0001;
					if (cnt_reg == 16'h0001) begin
						mem_reg <= '{req: 1'b1, wr: 1'b1, addr: ret_reg, wdata: p_reg};
						state_reg <= S_EFIX;
					end else begin
						mem_reg <= '{req: 1'b1, wr: 1'b0, addr: p_reg, wdata: 16'h0000};
						state_reg <= S_EPRM;
					end
				end
				S_EFIX: if (ack) begin
					// Return slot now holds true return point
					if (kind_reg == K_ENTER_PRIVILEGED_PARAMS) a_reg <= p_reg;
					p_reg <= dst_reg;
					mem_reg <= '0;
					done_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				S_FCNT: if (ack) begin
					// Count word; zero ends at once
					cnt_reg <= i_mem_rdata;
					p_reg <= p_reg + 16'h0001;
					if (i_mem_rdata == 16'h0000) begin
						mem_reg <= '0;
						done_reg <= 1'b1;
						state_reg <= S_IDLE;
					end else begin
						mem_reg <= '{req: 1'b1, wr: 1'b1, addr: seg(b_reg, i_cds, i_base),
							wdata: a_reg};
						state_reg <= S_FWR;
					end
				end
				S_FWR: if (ack) begin
					a_reg <= a_reg + 16'h0001;
					b_reg <= b_reg + 16'h0001;
					cnt_reg <= cnt_reg - 16'h0001;
					if (cnt_reg == 16'h0001) begin
						mem_reg <= '0;
						done_reg <= 1'b1;
						state_reg <= S_IDLE;
					end else if (i_irq) begin
						// Save remaining count in the count word, then restart later
						mem_reg <= '{req: 1'b1, wr: 1'b1, addr: p_reg - 16'h0001,
							wdata: cnt_reg - 16'h0001};
						state_reg <= S_FSAV;
					end else begin
						mem_reg <= '{req: 1'b1, wr: 1'b1,
							addr: seg(b_reg + 16'h0001, i_cds, i_base), wdata: a_reg + 16'h0001};
					end
				end
				S_FSAV: if (ack) begin
					// Resume point is the opcode itself
					p_reg <= p_reg - 16'h0002;
					mem_reg <= '0;
					intr_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Register move ends with A advanced by three
	property p_move_len;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		accept && dec_kind == K_XFER3 |-> ##[1:300] (o_done && o_acc.a == $past(i_acc.a, 1) + 16'h3);
	endproperty
	a_move_len: assert property (p_move_len) else $error("register move length wrong");
	// Unknown opcode starts nothing
	property p_reject;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_start && !o_busy && dec_kind == K_NONE |=> !o_busy;
	endproperty
	a_reject: assert property (p_reject) else $error("unknown opcode started");
	// Each further fill write carries the value from A plus one
	property p_fill_wr;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == S_FWR && ack && cnt_reg != 16'h1 && !i_irq |=>
			o_mem.wdata == $past(a_reg) + 16'h1;
	endproperty
	a_fill_wr: assert property (p_fill_wr) else $error("fill value not incremented");
	// Interrupted fill saves remaining count
	property p_fill_save;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == S_FWR && ack && cnt_reg != 16'h1 && i_irq |=>
			o_mem.wr && o_mem.wdata == $past(cnt_reg) - 16'h1;
	endproperty
	a_fill_save: assert property (p_fill_save) else $error("fill count not saved");
	// Privileged entry hands the written return point back in A
	property p_enter_privileged_params_ret;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == S_EFIX && ack && kind_reg == K_ENTER_PRIVILEGED_PARAMS |=> o_acc.a == $past(o_mem.wdata);
	endproperty
	a_enter_privileged_params_ret: assert property (p_enter_privileged_params_ret) else $error("entry return not in A");
	// Each fill write advances the address in B by one
	property p_fill_b;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == S_FWR && ack |=> o_acc.b == $past(b_reg) + 16'h1;
	endproperty
	a_fill_b: assert property (p_fill_b) else $error("fill address not advanced");
endmodule : lang_mv_seq

// ==== core/lang_mv_map.svh ====
// Offsets, opcode patterns and counts for the language move and parameter sequencer
`ifndef LANG_MV_MAP_SVH
`define LANG_MV_MAP_SVH
`define OP_MOVE8 16'h8a1f
`define OP_MOVE4 16'h8a17
`define OP_MOVE3 16'h8a16
`define OP_ENTER_PRIV 16'h8a94
`define OP_ENTER 16'h8a93
`define OP_XFER3 16'h8a90
`define OP_FILL 16'h8a87
`define IND_BIT 15
`define LEN_MOVE8 16'h0008
`define LEN_MOVE4 16'h0004
`define LEN_MOVE3 16'h0003
`define ENTER_GAP 16'h0002
`endif

// ==== core/lang_mv_pkg.sv ====
// Types shared by the language move and parameter sequencer
package lang_mv_pkg;
	// Instruction kind decoded from an opcode
	typedef enum logic [2:0] {K_NONE, K_MOVE8, K_MOVE4, K_MOVE3, K_XFER3, K_ENTER_PRIVILEGED_PARAMS, K_ENTER_PARAMS, K_FILL}
		kind_t;
	// Memory request carried to the memory port
	typedef struct packed {
		logic req;
		logic wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;
	// Accumulator pair
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
	} acc_t;
endpackage : lang_mv_pkg

// ==== dv/lang_mv_mem.sv ====
// Memory model that answers the sequencer's word requests
module lang_mv_mem (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire lang_mv_pkg::mem_req_t i_mem,
	input wire logic i_slow,
	output logic o_ack,
	output logic [15:0] o_rdata
);
	import lang_mv_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] m [0:65535]; // Word store
	logic [15:0] rd_reg; // Last word read
	int wait_reg; // Stall left before the next answer
	// Data lines show the inverse of the last word outside an answer
	assign o_rdata = o_ack ? rd_reg : ~rd_reg;
	// One answer per request, at once or after a random stall
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ack <= 1'b0;
			rd_reg <= 16'h0000;
			wait_reg <= 0;
		end else begin
			o_ack <= 1'b0;
			if (i_mem.req && !o_ack) begin
				if (wait_reg <= 0) begin
					o_ack <= 1'b1;
					wait_reg <= i_slow ? int'($urandom_range(3)) : 0;
					if (i_mem.wr) m[i_mem.addr] <= i_mem.wdata;
					else rd_reg <= m[i_mem.addr];
				end else wait_reg <= wait_reg - 1;
			end
		end
	end
endmodule : lang_mv_mem

// ==== dv/language_move_param_microcode_tb.sv ====
// Random and corner tests of the move and table-fill sequencer
`include "lang_mv_map.svh"
module language_move_param_microcode_tb;
	import lang_mv_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk, i_arst_n, i_start, i_irq, i_slow, ack, intr_seen;
	logic [15:0] i_opcode, i_p, rdata, o_p_next;
	logic i_cds; // Base-relative mode, used by moves only
	logic [15:0] i_base; // Base added to move data addresses
	acc_t i_acc, o_acc;
	mem_req_t o_mem;
	logic o_busy, o_done, o_intr;
	int miscompares, n_checks;
	// Base-relative mode held off in fill and entry tests: entry is undefined there
	lang_mv_seq uut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_start(i_start),
		.i_opcode(i_opcode), .i_p(i_p), .i_acc(i_acc), .i_irq(i_irq), .i_cds(i_cds),
		.i_base(i_base), .i_mem_ack(ack), .i_mem_rdata(rdata), .o_mem(o_mem),
		.o_acc(o_acc), .o_p_next(o_p_next), .o_busy(o_busy), .o_done(o_done),
		.o_intr(o_intr));
	lang_mv_mem mem (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_mem(o_mem),
		.i_slow(i_slow), .o_ack(ack), .o_rdata(rdata));
	// Prints the counts and the verdict, then stops
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	// Compares one word
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// Issues one instruction, waits for done or suspension
	task automatic run(input logic [15:0] op, p, a, b, input int irq_at);
		@(posedge i_sys_clk);
		#1;
		i_start = 1'b1;
		i_opcode = op;
		i_p = p;
		i_acc = '{a, b};
		@(posedge i_sys_clk);
		#1;
		i_start = 1'b0;
		for (int n = 0; n < 3000; n++) begin
			if (n == irq_at) i_irq = 1'b1;
			if (o_done === 1'b1 || o_intr === 1'b1) begin
				intr_seen = o_intr;
				i_irq = 1'b0;
				return;
			end
			@(posedge i_sys_clk);
			#1;
		end
		miscompares++;
		results();
	endtask : run
	// Clock
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// Main sequence
	initial begin
		logic [15:0] p, s, d, v, c, n;
		logic [15:0] ops [4] = '{`OP_MOVE8, `OP_MOVE4, `OP_MOVE3, `OP_XFER3};
		logic [15:0] w [8];
		i_arst_n = 1'b0;
		i_start = 1'b0;
		i_opcode = 16'h0000;
		i_p = 16'h0000;
		i_acc = '0;
		i_irq = 1'b0;
		i_slow = 1'b0;
		i_cds = 1'b0;
		i_base = 16'h0000;
		void'($urandom(32'h713a));
		repeat (2) @(posedge i_sys_clk);
		#1;
		i_arst_n = 1'b1;
		chk(o_acc.a, 16'h0000, "reset acc");
		// Pattern one off a move opcode must not start
		@(posedge i_sys_clk);
		#1;
		i_start = 1'b1;
		i_opcode = 16'h8a18;
		i_p = 16'h0100;
		@(posedge i_sys_clk);
		#1;
		i_start = 1'b0;
		chk({15'h0, o_busy}, 16'h0000, "odd opcode ran");
		// Moves of each length, random data, two-level indirect destination
		for (int t = 0; t < 24; t++) begin
			i_slow = t[0];
			i_cds = (t >= 16);
			i_base = i_cds ? 16'h0400 : 16'h0000;
			n = (t % 4 == 0) ? 16'h8 : (t % 4 == 1) ? 16'h4 : 16'h3;
			p = 16'h0100 + 16'(t * 16);
			s = 16'h1000 + 16'($urandom_range(255));
			d = 16'h2000 + 16'($urandom_range(255));
			for (int i = 0; i < 8; i++) begin
				w[i] = 16'($urandom);
				mem.m[s + i_base + 16'(i)] = w[i];
			end
			mem.m[d + i_base + n] = 16'h5a5a;
			mem.m[p + 16'h1] = 16'h8050;
			mem.m[16'h0050] = 16'h8051;
			mem.m[16'h0051] = d;
			mem.m[p + 16'h2] = s;
			run(ops[t % 4], p, s, d, -1);
			for (int i = 0; i < 8; i++) begin
				if (16'(i) < n) chk(mem.m[d + i_base + 16'(i)], w[i], "word");
			end
			chk(mem.m[d + i_base + n], 16'h5a5a, "overrun");
			chk(o_acc.a, s + n, "acc a");
			chk(o_acc.b, d + n, "acc b");
			chk(o_p_next, p + ((t % 4 == 3) ? 16'h1 : 16'h3), "next");
		end
		// Table fill: zero count, random counts, last one interrupted
		i_slow = 1'b0;
		i_cds = 1'b0;
		i_base = 16'h0000;
		for (int t = 0; t < 6; t++) begin
			c = (t == 0) ? 16'h0 : (t == 5) ? 16'h9 : 16'($urandom_range(1, 9));
			v = 16'($urandom);
			d = 16'h3000 + 16'(t * 16);
			p = 16'h0400 + 16'(t * 4);
			mem.m[p + 16'h1] = c;
			mem.m[d + c] = 16'h5a5a;
			run(`OP_FILL, p, v, d, (t == 5) ? 6 : -1);
			if (t == 5) begin
				chk({15'h0, intr_seen}, 16'h1, "no suspend");
				chk(o_p_next, p, "resume point");
				chk(mem.m[p + 16'h1] + o_acc.b - d, c, "count left");
				chk(o_acc.a - v, o_acc.b - d, "value step");
				run(`OP_FILL, p, o_acc.a, o_acc.b, -1);
			end
			for (int i = 0; i < 9; i++) begin
				if (16'(i) < c) chk(mem.m[d + 16'(i)], v + 16'(i), "entry");
			end
			chk(mem.m[d + c], 16'h5a5a, "overrun");
			chk(o_acc.a, v + c, "fill a");
			chk(o_acc.b, d + c, "fill b");
			chk(o_p_next, p + 16'h2, "fill next");
		end
		// Parameter entry, ordinary then privileged, one-level indirect parameter
		for (int t = 0; t < 2; t++) begin
			p = 16'h0600 + 16'(t * 16);
			s = p - ((t == 1) ? 16'h2 : 16'h1);
			c = 16'h0700 + 16'(t * 16);
			v = 16'($urandom) & 16'h7fff;
			mem.m[s] = c;
			mem.m[c] = 16'h8060 + 16'(t);
			mem.m[16'h0060 + 16'(t)] = v;
			run((t == 1) ? `OP_ENTER_PRIV : `OP_ENTER, p, 16'h0, 16'h0, -1);
			chk(mem.m[p + 16'h1], v, "param addr");
			chk(mem.m[s], c + 16'h1, "return slot");
			chk(o_p_next, p + 16'h2, "entry next");
			if (t == 1) chk(o_acc.a, c + 16'h1, "entry a");
		end
		results();
	end
endmodule : language_move_param_microcode_tb
